// File: test/tal_fe_model.sv
// front end and keypad operator model for the alarm relay bench
`timescale 1ns/1ps
module tal_fe_model (
  // clock
  input  wire logic        i_clk,
  // readings and keys toward the block
  output logic             o_valid,
  output logic      [15:0] o_read_k,
  output logic             o_over,
  output logic             o_under,
  output logic      [3:0]  o_keys
);
  // ==========================================================
  // idle levels at time zero
  initial begin
    o_valid  = 1'b0;
    o_read_k = 16'h0000;
    o_over   = 1'b0;
    o_under  = 1'b0;
    o_keys   = 4'h0;
  end
  // one reading pulse, then the data lines stop showing the last value
  task automatic read(input logic [15:0] k, input logic ov, input logic un);
    @(posedge i_clk);
    o_valid  <= 1'b1;
    o_read_k <= k;
    o_over   <= ov;
    o_under  <= un;
    @(posedge i_clk);
    o_valid  <= 1'b0;
    o_read_k <= ~k;
    o_over   <= ~ov;
    o_under  <= ~un;
  endtask : read
  // press one key long enough to pass the synchroniser, then release
  task automatic press(input int unsigned b);
    @(posedge i_clk);
    o_keys[b] <= 1'b1;
    repeat (5) @(posedge i_clk);
    o_keys[b] <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : press
endmodule : tal_fe_model

// File: test/tb_top.sv
// self-checking bench for the alarm and relay block
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, cyc, stb, we, vld, ov, un, hi, lo, r1, r2, ack;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [15:0] rk;
  logic [3:0]  keys;
  logic [1:0]  units;
  logic [2:0]  step;
  logic [1:0]  disp, ufmt;
  logic [15:0] ed;
  logic        ce, lock;
  int          bad_count, cmp_count;
  // ==========================================================
  // clock, parts and reset
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  tal_fe_model fe (.i_clk(clk), .o_valid(vld), .o_read_k(rk), .o_over(ov), .o_under(un),
                   .o_keys(keys));
  tal_alarm_relay #(.FLASH_CYCLES(8)) dut (.I_REF_CLK(clk), .I_ARST_N(rst_n), .I_CLK_EN(ce),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_READ_VALID(vld), .I_READ_K(rk),
    .I_CURVE_OVER(ov), .I_CURVE_UNDER(un), .I_USER_FMT(ufmt), .I_KEY_UP(keys[0]),
    .I_KEY_DOWN(keys[1]), .I_KEY_SELECT(keys[2]), .I_KEY_ENTER(keys[3]),
    .I_KEYPAD_LOCK(lock), .O_HIGH_ALARM(hi), .O_LOW_ALARM(lo), .O_RELAY1(r1),
    .O_RELAY2(r2), .O_DISP_SEL(disp), .O_UNITS(units), .O_MENU_STEP(step), .O_EDIT_VAL(ed));
  // ==========================================================
  // compare, bus and reading tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
    if (n >= 50) bad_count++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask : rc
  task automatic flags(input logic eh, input logic el, input logic e1, input logic e2);
    #1;
    chk("high", {31'h0, eh}, {31'h0, hi});
    chk("low", {31'h0, el}, {31'h0, lo});
    chk("relay1", {31'h0, e1}, {31'h0, r1});
    chk("relay2", {31'h0, e2}, {31'h0, r2});
  endtask : flags
  task automatic rd(input logic [15:0] k, input logic o, input logic u, input logic eh,
                    input logic el);
    fe.read(k, o, u);
    flags(eh, el, el, eh);
  endtask : rd
  // collects which display messages show up over four flash periods
  task automatic dsp(input logic [31:0] e);
    logic [31:0] m;
    m = 32'h0;
    repeat (32) begin
      @(posedge clk);
      m[disp] = 1'b1;
    end
    chk("disp", e, m);
  endtask : dsp
  task automatic results();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
  // ==========================================================
  // test sequence
  initial begin
    bad_count = 0; cmp_count = 0; rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; wdat = 32'h0; ce = 1'b1; lock = 1'b0; ufmt = 2'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("units", 32'h1, {30'h0, units});
    wr(8'h04, 32'hffff); rc("hisp", 8'h04, 32'h270f);
    wr(8'h08, 32'hffff); rc("losp", 8'h08, 32'h270f);
    wr(8'h0c, 32'hffff); rc("dband", 8'h0c, 32'h03e7);
    wr(8'h04, 32'h3e8); wr(8'h08, 32'h1f4); wr(8'h0c, 32'ha); wr(8'h00, 32'h69);
    rd(16'd1001, 0, 0, 1, 0);
    rd(16'd995, 0, 0, 1, 0);
    rd(16'd990, 0, 0, 0, 0);
    rd(16'd499, 0, 0, 0, 1);
    rd(16'd505, 0, 0, 0, 1);
    rd(16'd510, 0, 0, 0, 0);
    rd(16'd700, 1, 0, 1, 0);
    rd(16'd700, 0, 1, 0, 1);
    rd(16'd700, 0, 0, 0, 0);
    wr(8'h00, 32'h6b); rc("ctrl", 8'h00, 32'h6b);
    rd(16'd1001, 0, 0, 1, 0);
    rd(16'd499, 0, 0, 1, 1);
    rd(16'd700, 0, 0, 1, 1);
    dsp(32'h7);
    fe.press(2); flags(0, 0, 0, 0);
    chk("step", 32'h1, {29'h0, step});
    chk("edit", 32'h1, {16'h0, ed});
    fe.press(3); #1 chk("step", 32'h2, {29'h0, step});
    chk("edit", 32'h3e8, {16'h0, ed});
    fe.press(2); #1 chk("step", 32'h0, {29'h0, step});
    rd(16'd1001, 0, 0, 1, 0);
    dsp(32'h3);
    @(posedge clk) lock <= 1'b1;
    fe.press(2); flags(0, 0, 0, 0);
    chk("step", 32'h0, {29'h0, step});
    @(posedge clk) lock <= 1'b0;
    fe.press(2); fe.press(1); chk("edit", 32'h0, {16'h0, ed});
    fe.press(3); chk("step", 32'h0, {29'h0, step});
    rc("ctrl", 8'h00, 32'h6a);
    wr(8'h00, 32'h6b); rd(16'd1001, 0, 0, 1, 0);
    wr(8'h00, 32'h6a); #1 flags(0, 0, 0, 0);
    wr(8'h00, 32'h45); #1 flags(0, 0, 1, 0);
    wr(8'h00, 32'h51); #1 flags(0, 0, 0, 1);
    @(posedge clk) ce <= 1'b0;
    fe.read(16'd1001, 0, 0); flags(0, 0, 0, 1);
    @(posedge clk) ce <= 1'b1;
    wr(8'h00, 32'h69); wr(8'h10, 32'h006); rc("curve", 8'h10, 32'h001);
    wr(8'h10, 32'h000); #1 chk("units", 32'h0, {30'h0, units});
    rd(16'd1001, 0, 0, 0, 0);
    @(posedge clk) ufmt <= 2'h1;
    wr(8'h10, 32'h015); rc("curve", 8'h10, 32'h000);
    @(posedge clk) ufmt <= 2'h0;
    wr(8'h10, 32'h015); rc("curve", 8'h10, 32'h015);
    rc("unmapped", 8'hfc, 32'h0);
    results();
  end
endmodule : tb_top

// File: verilog/tal_alarm_relay.sv
// alarm, relay, curve and unit control for a single-input temperature monitor
// What this block does
// - high alarm above setpoint or curve top
// - low alarm below setpoint or curve bottom
// - compare in kelvin whatever the display units
// - no curve assigned keeps both alarms off
// - display alternates reading with active alarm message
// - latched alarm stays until select press, alarm disable or curve removal
// - select press clears all latched alarms
// - unlatched high clears after falling by deadband
// - enable off ends setup, alarms disabled
// - high setpoint clamped 0 to 999.9 K
// - low setpoint clamped 0 to 999.9 K
// - deadband clamped 0 to 99.9 K
// - latch setting is a single 0/1 flag
// - setup order enable high low deadband latch
// - relay one low alarm, relay two high
// - relay one off, on or follows low
// - relay two off, on or follows high
// - curve accepted only if format matches input
// - curve 0 none, 1-3 and 6-7 built-in, 21 user
// - temperature units only while a curve assigned
// - both alarms together only when latching
// - locked keypad keeps only the select clear
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
module tal_alarm_relay #(
  parameter int unsigned FLASH_CYCLES = tal_pkg::FLASH_CYC
) (
  // clock, reset, enable
  input  wire logic        I_REF_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_CLK_EN,
  // wishbone classic slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  // measurement front end
  input  wire logic        I_READ_VALID,
  input  wire logic [15:0] I_READ_K,
  input  wire logic        I_CURVE_OVER,
  input  wire logic        I_CURVE_UNDER,
  input  wire logic [1:0]  I_USER_FMT,
  // front panel keys and lock
  input  wire logic        I_KEY_UP,
  input  wire logic        I_KEY_DOWN,
  input  wire logic        I_KEY_SELECT,
  input  wire logic        I_KEY_ENTER,
  input  wire logic        I_KEYPAD_LOCK,
  // alarms, relays and display
  output logic             O_HIGH_ALARM,
  output logic             O_LOW_ALARM,
  output logic             O_RELAY1,
  output logic             O_RELAY2,
  output logic      [1:0]  O_DISP_SEL,
  output logic      [1:0]  O_UNITS,
  output logic      [2:0]  O_MENU_STEP,
  output logic      [15:0] O_EDIT_VAL
);
  // ==========================================================
  // key synchronisers and press detection
  logic [3:0] key_raw;
  logic [3:0] key_m_q;
  logic [3:0] key_s_q;
  logic [3:0] key_o_q;
  logic [3:0] key_p;
  assign key_raw = {I_KEY_ENTER, I_KEY_SELECT, I_KEY_DOWN, I_KEY_UP};
  genvar gk;
  generate
    for (gk = 0; gk < 4; gk++) begin : g_key
      // two-stage synchroniser, then a delayed copy for the rising edge
      always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          key_m_q[gk] <= 1'b0;
          key_s_q[gk] <= 1'b0;
          key_o_q[gk] <= 1'b0;
        end else if (I_CLK_EN) begin
          key_m_q[gk] <= key_raw[gk];
          key_s_q[gk] <= key_m_q[gk];
          key_o_q[gk] <= key_s_q[gk];
        end
      end
      assign key_p[gk] = key_s_q[gk] & ~key_o_q[gk];
    end
  endgenerate
  logic lock_m_q;
  logic lock_q;
  // lock level synchroniser
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      lock_m_q <= 1'b0;
      lock_q   <= 1'b0;
    end else if (I_CLK_EN) begin
      lock_m_q <= I_KEYPAD_LOCK;
      lock_q   <= lock_m_q;
    end
  end
  logic up_p, dn_p, sel_p, ent_p, clr_p;
  assign clr_p = key_p[2];                // alarm clear works even when locked
  assign up_p  = key_p[0] & ~lock_q;
  assign dn_p  = key_p[1] & ~lock_q;
  assign sel_p = key_p[2] & ~lock_q;
  assign ent_p = key_p[3] & ~lock_q;
  // ==========================================================
  // configuration state
  tal_pkg::tal_cfg_s cfg_q;
  logic [15:0]       hi_sp_q;
  logic [15:0]       lo_sp_q;
  logic [15:0]       db_q;
  logic              curve_on;
  assign curve_on = (cfg_q.curve != tal_pkg::CRV_NONE);
  // format carried by a curve number; unknown numbers are rejected
  function automatic logic curve_fits(input logic [4:0] c, input logic [2:0] t,
                                      input logic [1:0] ufmt);
    tal_pkg::tal_fmt_e want;
    logic              ok;
    want = (t < 3'h2) ? tal_pkg::FMT_VK : (t < 3'h5) ? tal_pkg::FMT_OHMK
         : tal_pkg::FMT_LOGOHMK;
    case (c)
      5'h00:                      ok = 1'b1;
      5'h01, 5'h02, 5'h03:        ok = (want == tal_pkg::FMT_VK);
      5'h06, 5'h07:               ok = (want == tal_pkg::FMT_OHMK);
      tal_pkg::CRV_USER:          ok = (ufmt == want);
      default:                    ok = 1'b0;
    endcase
    return ok;
  endfunction : curve_fits
  // byte-lane merge of a write into the present value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx);
    return (v > mx) ? mx : v;
  endfunction : clamp
  // ==========================================================
  // wishbone decode and read mux
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] rd_ctrl, rd_curve, rd_stat, rd_mux, wb_wdat;
  logic        hi_q, lo_q;
  tal_pkg::tal_disp_e disp_q;
  tal_pkg::tal_menu_e menu_q;
  assign wb_req   = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  assign wb_wr    = wb_req & I_WB_WE & I_CLK_EN;
  assign rd_ctrl  = {24'h000000, cfg_q.units, cfg_q.r2_mode, cfg_q.r1_mode,
                     cfg_q.latch, cfg_q.alarm_en};
  assign rd_curve = {21'h000000, cfg_q.in_type, 3'h0, cfg_q.curve};
  assign rd_stat  = {21'h000000, menu_q, 1'b0, disp_q, curve_on, O_RELAY2, O_RELAY1, lo_q, hi_q};
  always_comb begin
    case (I_WB_ADR)
      tal_pkg::ADR_CTRL:  rd_mux = rd_ctrl;
      tal_pkg::ADR_HIGH:  rd_mux = {16'h0000, hi_sp_q};
      tal_pkg::ADR_LOW:   rd_mux = {16'h0000, lo_sp_q};
      tal_pkg::ADR_DBAND: rd_mux = {16'h0000, db_q};
      tal_pkg::ADR_CURVE: rd_mux = rd_curve;
      tal_pkg::ADR_STAT:  rd_mux = rd_stat;
      default:            rd_mux = 32'h00000000;
    endcase
  end
  assign wb_wdat = merge(rd_mux, I_WB_DAT, I_WB_SEL);
  // one-wait-state acknowledge, read data registered with it
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
    end else if (I_CLK_EN) begin
      O_WB_ACK <= wb_req;
      O_WB_DAT <= wb_req ? rd_mux : 32'h00000000;
    end
  end
  // ==========================================================
  // front panel setup sequence
  logic [15:0] edit_q;
  logic [15:0] edit_max;
  logic        commit;
  always_comb begin
    case (menu_q)
      tal_pkg::M_HIGH, tal_pkg::M_LOW: edit_max = tal_pkg::SP_MAX;
      tal_pkg::M_DBAND:   edit_max = tal_pkg::DB_MAX;
      default:            edit_max = tal_pkg::FLAG_MAX;
    endcase
  end
  assign commit = ent_p & (menu_q != tal_pkg::M_IDLE);
  // menu walks in fixed order, each enter commits and moves on
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      menu_q <= tal_pkg::M_IDLE;
      edit_q <= 16'h0000;
    end else if (I_CLK_EN) begin
      case (menu_q)
        tal_pkg::M_IDLE: begin
          if (sel_p) begin
            menu_q <= tal_pkg::M_ENABLE;
            edit_q <= {15'h0000, cfg_q.alarm_en};
          end
        end
        tal_pkg::M_ENABLE, tal_pkg::M_HIGH, tal_pkg::M_LOW,
        tal_pkg::M_DBAND, tal_pkg::M_LATCH: begin
          if (sel_p) begin
            menu_q <= tal_pkg::M_IDLE;                      // cancel, earlier commits kept
          end else if (ent_p) begin
            case (menu_q)
              tal_pkg::M_ENABLE: begin
                menu_q <= (edit_q == 16'h0000) ? tal_pkg::M_IDLE : tal_pkg::M_HIGH;
                edit_q <= hi_sp_q;
              end
              tal_pkg::M_HIGH: begin
                menu_q <= tal_pkg::M_LOW;
                edit_q <= lo_sp_q;
              end
              tal_pkg::M_LOW: begin
                menu_q <= tal_pkg::M_DBAND;
                edit_q <= db_q;
              end
              tal_pkg::M_DBAND: begin
                menu_q <= tal_pkg::M_LATCH;
                edit_q <= {15'h0000, cfg_q.latch};
              end
              default: menu_q <= tal_pkg::M_IDLE;
            endcase
          end else if (up_p && edit_q < edit_max) begin
            edit_q <= edit_q + 16'h0001;
          end else if (dn_p && edit_q != 16'h0000) begin
            edit_q <= edit_q - 16'h0001;
          end
        end
        default: menu_q <= tal_pkg::M_IDLE;
      endcase
    end
  end
  // configuration written by bus or committed from the panel
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg_q.alarm_en <= 1'b0;
      cfg_q.latch    <= 1'b0;
      cfg_q.r1_mode  <= tal_pkg::RLY_OFF;
      cfg_q.r2_mode  <= tal_pkg::RLY_OFF;
      cfg_q.units    <= tal_pkg::UNIT_K;
      cfg_q.curve    <= tal_pkg::RST_CURVE;
      cfg_q.in_type  <= tal_pkg::RST_TYPE;
      hi_sp_q        <= tal_pkg::RST_SP;
      lo_sp_q        <= tal_pkg::RST_SP;
      db_q           <= tal_pkg::RST_SP;
    end else if (I_CLK_EN) begin
      if (wb_wr && I_WB_ADR == tal_pkg::ADR_CTRL) begin
        cfg_q.alarm_en <= wb_wdat[tal_pkg::CTL_EN];
        cfg_q.latch    <= wb_wdat[tal_pkg::CTL_LATCH];
        cfg_q.r1_mode  <= tal_pkg::tal_relay_e'(wb_wdat[tal_pkg::CTL_R1 +: 2]);
        cfg_q.r2_mode  <= tal_pkg::tal_relay_e'(wb_wdat[tal_pkg::CTL_R2 +: 2]);
        if (curve_on || wb_wdat[tal_pkg::CTL_UNITS +: 2] == 2'h0) begin
          cfg_q.units <= tal_pkg::tal_units_e'(wb_wdat[tal_pkg::CTL_UNITS +: 2]);
        end
      end
      if (wb_wr && I_WB_ADR == tal_pkg::ADR_CURVE &&
          curve_fits(wb_wdat[tal_pkg::CRV_ID +: 5], wb_wdat[tal_pkg::CRV_TYPE +: 3],
                     I_USER_FMT)) begin
        cfg_q.curve   <= wb_wdat[tal_pkg::CRV_ID +: 5];
        cfg_q.in_type <= wb_wdat[tal_pkg::CRV_TYPE +: 3];
        if (wb_wdat[tal_pkg::CRV_ID +: 5] == tal_pkg::CRV_NONE) begin
          cfg_q.units <= tal_pkg::UNIT_SENSOR;
        end
      end
      if (wb_wr && I_WB_ADR == tal_pkg::ADR_HIGH) begin
        hi_sp_q <= clamp(wb_wdat[15:0], tal_pkg::SP_MAX);
      end
      if (wb_wr && I_WB_ADR == tal_pkg::ADR_LOW) begin
        lo_sp_q <= clamp(wb_wdat[15:0], tal_pkg::SP_MAX);
      end
      if (wb_wr && I_WB_ADR == tal_pkg::ADR_DBAND) begin
        db_q <= clamp(wb_wdat[15:0], tal_pkg::DB_MAX);
      end
      if (commit) begin
        case (menu_q)
          tal_pkg::M_ENABLE: cfg_q.alarm_en <= edit_q[0];
          tal_pkg::M_HIGH:   hi_sp_q        <= edit_q;
          tal_pkg::M_LOW:    lo_sp_q        <= edit_q;
          tal_pkg::M_DBAND:  db_q           <= edit_q;
          tal_pkg::M_LATCH:  cfg_q.latch    <= edit_q[0];
          default:  cfg_q.latch    <= cfg_q.latch;
        endcase
      end
    end
  end
  // ==========================================================
  // alarm evaluation, all in tenths of a kelvin
  logic        alarm_ok;
  logic [16:0] rd_k, hi_k, lo_k, db_k;
  logic        hi_cond, lo_cond, hi_hold, lo_hold, hi_d, lo_d, hi_set, lo_set;
  assign alarm_ok = cfg_q.alarm_en & curve_on;
  assign rd_k     = {1'b0, I_READ_K};
  assign hi_k     = {1'b0, hi_sp_q};
  assign lo_k     = {1'b0, lo_sp_q};
  assign db_k     = {1'b0, db_q};
  assign hi_cond  = I_CURVE_OVER | (rd_k > hi_k);
  assign lo_cond  = I_CURVE_UNDER | (rd_k < lo_k);
  assign hi_hold  = I_CURVE_OVER | (rd_k + db_k > hi_k);
  assign lo_hold  = I_CURVE_UNDER | (rd_k < lo_k + db_k);
  assign hi_set   = I_READ_VALID & hi_cond;
  assign lo_set   = I_READ_VALID & lo_cond;
  always_comb begin
    if (!alarm_ok) begin
      hi_d = 1'b0;
      lo_d = 1'b0;
    end else if (cfg_q.latch) begin
      hi_d = hi_set | (hi_q & ~clr_p);
      lo_d = lo_set | (lo_q & ~clr_p);
    end else if (I_READ_VALID) begin
      hi_d = hi_q ? hi_hold : hi_cond;
      lo_d = (lo_q ? lo_hold : lo_cond) & ~(hi_q ? hi_hold : hi_cond);
    end else begin
      hi_d = hi_q;
      lo_d = lo_q & ~hi_q;
    end
  end
  // alarm flags
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else if (I_CLK_EN) begin
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end
  // ==========================================================
  // relays
  always_comb begin
    case (cfg_q.r1_mode)
      tal_pkg::RLY_ON:     O_RELAY1 = 1'b1;
      tal_pkg::RLY_FOLLOW: O_RELAY1 = lo_q;
      default:             O_RELAY1 = 1'b0;
    endcase
    case (cfg_q.r2_mode)
      tal_pkg::RLY_ON:     O_RELAY2 = 1'b1;
      tal_pkg::RLY_FOLLOW: O_RELAY2 = hi_q;
      default:             O_RELAY2 = 1'b0;
    endcase
  end
  // ==========================================================
  // display alternation between reading and active messages
  logic [31:0] flash_q;
  logic        tick;
  assign tick = (flash_q == FLASH_CYCLES - 1);
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      flash_q <= 32'h00000000;
    end else if (I_CLK_EN) begin
      flash_q <= tick ? 32'h00000000 : flash_q + 32'h00000001;
    end
  end
  // steps reading, high message, low message, skipping inactive ones
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      disp_q <= tal_pkg::DSP_READING;
    end else if (I_CLK_EN) begin
      case (disp_q)
        tal_pkg::DSP_READING: begin
          if (tick) begin
            disp_q <= hi_q ? tal_pkg::DSP_HIGH : lo_q ? tal_pkg::DSP_LOW
                    : tal_pkg::DSP_READING;
          end
        end
        tal_pkg::DSP_HIGH: begin
          if (!hi_q) begin
            disp_q <= tal_pkg::DSP_READING;
          end else if (tick) begin
            disp_q <= lo_q ? tal_pkg::DSP_LOW : tal_pkg::DSP_READING;
          end
        end
        tal_pkg::DSP_LOW: begin
          if (!lo_q || tick) begin
            disp_q <= tal_pkg::DSP_READING;
          end
        end
        default: disp_q <= tal_pkg::DSP_READING;
      endcase
    end
  end
  // ==========================================================
  // outputs
  assign O_HIGH_ALARM = hi_q;
  assign O_LOW_ALARM  = lo_q;
  assign O_DISP_SEL   = disp_q;
  assign O_UNITS      = cfg_q.units;
  assign O_MENU_STEP  = menu_q;
  assign O_EDIT_VAL   = edit_q;
  // ==========================================================
  // assertions
  property p_off_no_curve;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      (I_CLK_EN && !alarm_ok) |=> (!hi_q && !lo_q);
  endproperty
  a_off_no_curve: assert property (p_off_no_curve) else $error("alarm while disabled");
  property p_hi_trigger;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      (I_CLK_EN && alarm_ok && I_READ_VALID && rd_k > hi_k) |=> hi_q;
  endproperty
  a_hi_trigger: assert property (p_hi_trigger) else $error("high alarm missed");
  property p_lo_trigger;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      (I_CLK_EN && alarm_ok && cfg_q.latch && I_READ_VALID && rd_k < lo_k) |=> lo_q;
  endproperty
  a_lo_trigger: assert property (p_lo_trigger) else $error("low alarm missed");
  property p_latch_hold;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      (I_CLK_EN && alarm_ok && cfg_q.latch && hi_q && !clr_p) |=> hi_q;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched alarm dropped");
  property p_no_both;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      ($past(I_CLK_EN) && $past(!cfg_q.latch) && !cfg_q.latch) |-> !(hi_q && lo_q);
  endproperty
  a_no_both: assert property (p_no_both) else $error("both alarms unlatched");
  property p_relay2;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      (cfg_q.r2_mode == tal_pkg::RLY_FOLLOW) |-> (O_RELAY2 == O_HIGH_ALARM);
  endproperty
  a_relay2: assert property (p_relay2) else $error("relay two not following");
  property p_sp_range;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      (hi_sp_q <= tal_pkg::SP_MAX) && (lo_sp_q <= tal_pkg::SP_MAX) && (db_q <= tal_pkg::DB_MAX);
  endproperty
  a_sp_range: assert property (p_sp_range) else $error("setpoint out of range");
  property p_enable_exit;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      (I_CLK_EN && menu_q == tal_pkg::M_ENABLE && ent_p && !sel_p && edit_q == 16'h0000)
      |=> (menu_q == tal_pkg::M_IDLE) && !cfg_q.alarm_en;
  endproperty
  a_enable_exit: assert property (p_enable_exit) else $error("setup did not end");
  property p_lock;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      (I_CLK_EN && lock_q && menu_q == tal_pkg::M_IDLE) |=> (menu_q == tal_pkg::M_IDLE);
  endproperty
  a_lock: assert property (p_lock) else $error("menu opened while locked");
endmodule : tal_alarm_relay

// File: verilog/tal_pkg.sv
// shared constants, types and register map of the temperature alarm and relay block
package tal_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned FLASH_MS   = 500;
  localparam int unsigned FLASH_CYC  = (CLK_HZ / 1000) * FLASH_MS;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0]  ADR_CTRL   = 8'h00;
  localparam logic [7:0]  ADR_HIGH   = 8'h04;
  localparam logic [7:0]  ADR_LOW    = 8'h08;
  localparam logic [7:0]  ADR_DBAND  = 8'h0c;
  localparam logic [7:0]  ADR_CURVE  = 8'h10;
  localparam logic [7:0]  ADR_STAT   = 8'h14;
  // ==========================================================
  // field positions
  localparam int          CTL_EN     = 0;
  localparam int          CTL_LATCH  = 1;
  localparam int          CTL_R1     = 2;
  localparam int          CTL_R2     = 4;
  localparam int          CTL_UNITS  = 6;
  localparam int          CRV_ID     = 0;
  localparam int          CRV_TYPE   = 8;
  localparam int          ST_HIGH    = 0;
  localparam int          ST_LOW     = 1;
  localparam int          ST_RLY1    = 2;
  localparam int          ST_RLY2    = 3;
  localparam int          ST_CRVON   = 4;
  localparam int          ST_DISP    = 5;
  localparam int          ST_MENU    = 8;
  // ==========================================================
  // limits in tenths of a kelvin, and curve numbers
  localparam logic [15:0] SP_MAX     = 16'h270f;
  localparam logic [15:0] DB_MAX     = 16'h03e7;
  localparam logic [15:0] FLAG_MAX   = 16'h0001;
  localparam logic [4:0]  CRV_NONE   = 5'h00;
  localparam logic [4:0]  CRV_USER   = 5'h15;
  // ==========================================================
  // reset values
  localparam logic [15:0] RST_SP     = 16'h0000;
  localparam logic [4:0]  RST_CURVE  = 5'h01;
  localparam logic [2:0]  RST_TYPE   = 3'h0;
  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {RLY_OFF, RLY_ON, RLY_FOLLOW}           tal_relay_e;
  typedef enum logic [1:0] {UNIT_SENSOR, UNIT_K, UNIT_C, UNIT_F}  tal_units_e;
  typedef enum logic [1:0] {FMT_VK, FMT_OHMK, FMT_LOGOHMK}        tal_fmt_e;
  typedef enum logic [1:0] {DSP_READING, DSP_HIGH, DSP_LOW}       tal_disp_e;
  typedef enum logic [2:0] {M_IDLE, M_ENABLE, M_HIGH, M_LOW, M_DBAND, M_LATCH} tal_menu_e;
  // ==========================================================
  // configuration carrier
  typedef struct packed {
    logic       alarm_en;
    logic       latch;
    tal_relay_e r1_mode;
    tal_relay_e r2_mode;
    tal_units_e units;
    logic [4:0] curve;
    logic [2:0] in_type;
  } tal_cfg_s;
endpackage : tal_pkg
